/* File: dcc_top.sv */
/*
 * DMA channel control block: per-channel control words, priority arbiter,
 * a one-at-a-time transaction engine on the system bus, chaining between
 * neighbours and an interrupt status/mask pair, all behind classic Wishbone.
 * Assumes event inputs are one-cycle pulses synchronous to clk_sys and that
 * the system bus answers each transaction with a one-cycle xfer_ack.
 */
// What this block does
// RL1: busy bit reads channel active or enabled
// RL2: direction bit picks which neighbour chains us
// RL3: direction ignored unless chaining is permitted
// RL4: enable bit turns the channel on/off
// RL5: events while off registered only if allowed
// RL6: chain permit allows neighbour completion to enable
// RL7: auto bit keeps channel on after block
// RL8: event flag reads one after detected event
// RL9: two-bit priority, three highest, zero lowest
// RL10: disable finishes running transaction before suspending
// RL11: unimplemented control bits read zero, ignore writes
// RL12: highest priority wins, ties to lower channel
// RL13: control bits reset to zero, channel off
`timescale 1ns/1ps
`default_nettype none

module dcc_top
    import dcc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [NUM_CH-1:0] start_evt,
    input wire logic [NUM_CH-1:0] abort_evt,
    output logic xfer_req,
    output logic [CH_W-1:0] xfer_chan,
    input wire logic xfer_ack,
    output logic irq
);

    logic ack_q;
    logic [31:0] rdat_q;
    logic [INT_W-1:0] int_stat_q, int_mask_q, int_set;
    dcc_eng_e eng_q;
    logic [CH_W-1:0] chan_q;
    logic [NUM_CH-1:0] req, dir, done, abort_seen, chain_src, active, wr_ch;
    logic [31:0] ctrl_rd [NUM_CH];
    logic [PRI_W-1:0] prio [NUM_CH];
    logic [31:0] wr_merged;
    logic bus_req, wr_go, any_req;
    logic [CH_W-1:0] win;
    logic [PRI_W-1:0] win_prio;
    logic [ADR_W-1:0] ctrl_end;

    // ----------------------------------------------------------------
    // wishbone slave: ack one cycle after the request, write on that edge
    // ----------------------------------------------------------------
    assign bus_req = wb_cyc_i & wb_stb_i;
    assign wr_go = bus_req & wb_we_i & ack_q;
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign ctrl_end = CTRL_BASE + ADR_W'(4 * NUM_CH);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req & ~ack_q;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdat_q <= 32'h0000_0000;
        end else if (bus_req && !ack_q) begin
            if (wb_adr_i >= CTRL_BASE && wb_adr_i < ctrl_end) begin
                rdat_q <= ctrl_rd[wb_adr_i[CH_W+1:2]];
            end else if (wb_adr_i == INT_STAT_OFS) begin
                rdat_q <= {24'h000000, int_stat_q};
            end else if (wb_adr_i == INT_MASK_OFS) begin
                rdat_q <= {24'h000000, int_mask_q};
            end else begin
                rdat_q <= 32'h0000_0000;
            end
        end
    end

    // only the low two byte lanes hold control bits; busy is never written
    always_comb begin
        wr_merged = ctrl_rd[wb_adr_i[CH_W+1:2]];
        if (wb_sel_i[0]) begin
            wr_merged[7:0] = wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
            wr_merged[15:8] = wb_dat_i[15:8];
        end
    end

    // ----------------------------------------------------------------
    // channels and chaining
    // ----------------------------------------------------------------
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        assign wr_ch[i] = wr_go && wb_adr_i >= CTRL_BASE && wb_adr_i < ctrl_end
                          && wb_adr_i[CH_W+1:2] == CH_W'(i);
        assign active[i] = (eng_q == ENG_RUN) && chan_q == CH_W'(i);
        if (i == 0) begin : g_first
            assign chain_src[i] = dir[i] ? done[i+1] : 1'b0;          // [RL2]
        end else if (i == NUM_CH - 1) begin : g_last
            assign chain_src[i] = dir[i] ? 1'b0 : done[i-1];          // [RL2]
        end else begin : g_mid
            assign chain_src[i] = dir[i] ? done[i+1] : done[i-1];     // [RL2]
        end

        dcc_channel u_ch (
            .clk_sys(clk_sys),
            .rst(rst),
            .wr_en(wr_ch[i]),
            .wr_data(wr_merged),
            .start_evt(start_evt[i]),
            .abort_evt(abort_evt[i]),
            .chain_src(chain_src[i]),
            .active(active[i]),
            .txn_done(xfer_ack),
            .ctrl_rd(ctrl_rd[i]),
            .req(req[i]),
            .prio(prio[i]),
            .dir(dir[i]),
            .block_done(done[i]),
            .abort_seen(abort_seen[i])
        );

        AST_PRIO_WIN: assert property (@(posedge clk_sys) disable iff (rst) // [RL12]
            eng_q == ENG_IDLE && req[i] |-> win_prio >= prio[i] && req[win])
            else $error("lower priority channel granted");
        AST_TIE_LOW: assert property (@(posedge clk_sys) disable iff (rst) // [RL12]
            eng_q == ENG_IDLE && req[i] && prio[i] == win_prio |-> win <= CH_W'(i))
            else $error("tie not broken to lower channel");
        AST_SUSPEND_BUSY: assert property (@(posedge clk_sys) disable iff (rst) // [RL10]
            active[i] && !xfer_ack |=> active[i] && ctrl_rd[i][BIT_BUSY])
            else $error("channel left a running transaction");
    end

    // ----------------------------------------------------------------
    // arbiter: strict greater-than keeps the lower channel on a tie
    // ----------------------------------------------------------------
    always_comb begin
        any_req = 1'b0;
        win = '0;
        win_prio = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            if (req[i] && (!any_req || prio[i] > win_prio)) begin     // [RL12]
                any_req = 1'b1;
                win = CH_W'(i);
                win_prio = prio[i];
            end
        end
    end

    // ----------------------------------------------------------------
    // transaction engine: one bus transaction at a time, never cut short
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            eng_q <= ENG_IDLE;
            chan_q <= '0;
        end else begin
            unique case (eng_q)
                ENG_IDLE: begin
                    if (any_req) begin
                        eng_q <= ENG_RUN;
                        chan_q <= win;
                    end
                end
                ENG_RUN: begin
                    if (xfer_ack) begin
                        eng_q <= ENG_IDLE;                            // [RL10]
                    end
                end
            endcase
        end
    end

    assign xfer_req = (eng_q == ENG_RUN);
    assign xfer_chan = chan_q;

    // ----------------------------------------------------------------
    // interrupts: block done in low bits, abort in high bits
    // ----------------------------------------------------------------
    assign int_set = {abort_seen, done};

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            int_stat_q <= INT_RST;
        end else begin
            for (int b = 0; b < INT_W; b++) begin
                if (int_set[b]) begin
                    int_stat_q[b] <= 1'b1;
                end else if (wr_go && wb_adr_i == INT_STAT_OFS && wb_sel_i[0] && wb_dat_i[b]) begin
                    int_stat_q[b] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            int_mask_q <= INT_RST;
        end else if (wr_go && wb_adr_i == INT_MASK_OFS && wb_sel_i[0]) begin
            int_mask_q <= wb_dat_i[INT_W-1:0];
        end
    end

    assign irq = |(int_stat_q & int_mask_q);

    AST_WB_ACK: assert property (@(posedge clk_sys) disable iff (rst)
        bus_req && !ack_q |=> ack_q ##1 !ack_q) else $error("bus ack not one cycle after request");
    AST_ENG_HOLD: assert property (@(posedge clk_sys) disable iff (rst) // [RL10]
        xfer_req && !xfer_ack |=> xfer_req && $stable(xfer_chan)) else $error("transaction dropped early");

    // ----------------------------------------------------------------
    // engine, bus and status checks
    // ----------------------------------------------------------------
    AST_GRANT: assert property (@(posedge clk_sys) disable iff (rst) // [RL12]
        eng_q == ENG_IDLE && any_req |=> xfer_req && xfer_chan == $past(win)) else $error("winner not granted");
    AST_NO_GRANT: assert property (@(posedge clk_sys) disable iff (rst) // [RL4]
        eng_q == ENG_IDLE && !any_req |=> !xfer_req) else $error("transaction without request");
    AST_IDLE_GAP: assert property (@(posedge clk_sys) disable iff (rst) // [RL10]
        xfer_req && xfer_ack |=> !xfer_req) else $error("no idle cycle after transaction");
    // a same-cycle clear must never swallow a fresh event
    AST_STAT_SET: assert property (@(posedge clk_sys) disable iff (rst)
        |int_set |=> (int_stat_q & $past(int_set)) == $past(int_set)) else $error("status event lost");
    AST_ACK_CAUSE: assert property (@(posedge clk_sys) disable iff (rst)
        wb_ack_o |-> $past(bus_req)) else $error("bus ack without request");

endmodule

`default_nettype wire

/* File: dcc_pkg.sv */
/*
 * Constants shared by the DMA channel control block: bit positions of the
 * channel control word, register offsets, reset values and transfer counts.
 * Assumes a 32-bit classic Wishbone register bus and a 250 MHz system clock.
 */
package dcc_pkg;

    // ----------------------------------------------------------------
    // channel count and transfer sizing
    // ----------------------------------------------------------------
    localparam int NUM_CH = 4;
    localparam int CH_W = 2;
    localparam int CNT_W = 8;
    // bus transactions that make up one block
    localparam logic [CNT_W-1:0] BLOCK_TXNS = 8'h04;

    // ----------------------------------------------------------------
    // channel control word layout
    // ----------------------------------------------------------------
    localparam int BIT_BUSY = 15;
    localparam int BIT_DIR = 8;
    localparam int BIT_ON = 7;
    localparam int BIT_ALLOW = 6;
    localparam int BIT_PERMIT = 5;
    localparam int BIT_AUTO = 4;
    localparam int BIT_SEEN = 2;
    localparam int PRI_LSB = 0;
    localparam int PRI_W = 2;
    localparam logic [PRI_W-1:0] PRI_RST = 2'h0;

    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam int ADR_W = 8;
    localparam logic [ADR_W-1:0] CTRL_BASE = 8'h00;
    localparam logic [ADR_W-1:0] INT_STAT_OFS = 8'h40;
    localparam logic [ADR_W-1:0] INT_MASK_OFS = 8'h44;
    localparam int INT_W = 2 * NUM_CH;
    localparam logic [INT_W-1:0] INT_RST = 8'h00;

    typedef enum logic [0:0] {ENG_IDLE, ENG_RUN} dcc_eng_e;

endpackage

/* File: dcc_channel.sv */
/*
 * One DMA channel's control word and sequencing: enable, chaining, event
 * capture, block counting and the busy indication.
 * Assumes the engine marks it active while a bus transaction runs for it and
 * pulses txn_done once per finished transaction.
 */
`timescale 1ns/1ps
`default_nettype none

module dcc_channel
    import dcc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [31:0] wr_data,
    input wire logic start_evt,
    input wire logic abort_evt,
    input wire logic chain_src,
    input wire logic active,
    input wire logic txn_done,
    output logic [31:0] ctrl_rd,
    output logic req,
    output logic [PRI_W-1:0] prio,
    output logic dir,
    output logic block_done,
    output logic abort_seen
);

    logic on_q, dir_q, allow_q, permit_q, auto_q, seen_q, pending_q;
    logic [PRI_W-1:0] prio_q;
    logic [CNT_W-1:0] cnt_q;
    logic accept, start_ok, abort_ok, chain_hit, busy;

    assign accept = on_q | allow_q;                                  // [RL5]
    assign start_ok = start_evt & accept;                             // [RL5]
    assign abort_ok = abort_evt & accept;                             // [RL5]
    // direction only matters through this gate
    assign chain_hit = chain_src & permit_q;                          // [RL3] [RL6]
    assign block_done = txn_done & active & ~abort_ok & (cnt_q == BLOCK_TXNS - 8'h01);
    assign abort_seen = abort_ok;
    // a suspended channel keeps busy until its running transaction ends
    assign busy = on_q | active;                                      // [RL1] [RL10]
    assign req = on_q & pending_q;                                    // [RL4] [RL10]
    assign prio = prio_q;
    assign dir = dir_q;

    // ----------------------------------------------------------------
    // enable: a chain start wins over a clearing write
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            on_q <= 1'b0;                                             // [RL13]
        end else if (chain_hit) begin
            on_q <= 1'b1;                                             // [RL6]
        end else if (wr_en) begin
            on_q <= wr_data[BIT_ON];                                  // [RL4]
        end else if (block_done && !auto_q) begin
            on_q <= 1'b0;                                             // [RL7]
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dir_q <= 1'b0;                                            // [RL13]
            allow_q <= 1'b0;
            permit_q <= 1'b0;
            auto_q <= 1'b0;
            prio_q <= PRI_RST;
        end else if (wr_en) begin
            dir_q <= wr_data[BIT_DIR];
            allow_q <= wr_data[BIT_ALLOW];
            permit_q <= wr_data[BIT_PERMIT];
            auto_q <= wr_data[BIT_AUTO];
            prio_q <= wr_data[PRI_LSB +: PRI_W];                      // [RL9]
        end
    end

    // ----------------------------------------------------------------
    // pending start, event flag and block counter
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pending_q <= 1'b0;
        end else if (abort_ok) begin
            pending_q <= 1'b0;
        end else if (start_ok) begin
            pending_q <= 1'b1;
        end else if (block_done) begin
            pending_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            seen_q <= 1'b0;
        end else if (abort_ok) begin
            // abort beats a start in the same cycle, as it does for pending
            seen_q <= 1'b0;
        end else if (start_ok) begin
            seen_q <= 1'b1;                                           // [RL8]
        end else if (block_done || abort_ok) begin
            seen_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (abort_ok || block_done) begin
            cnt_q <= '0;
        end else if (txn_done && active && pending_q) begin
            // a transaction still running when an abort lands must not count toward the next block
            cnt_q <= cnt_q + 8'h01;
        end
    end

    always_comb begin
        ctrl_rd = 32'h0000_0000;                                      // [RL11]
        ctrl_rd[BIT_BUSY] = busy;
        ctrl_rd[BIT_DIR] = dir_q;
        ctrl_rd[BIT_ON] = on_q;
        ctrl_rd[BIT_ALLOW] = allow_q;
        ctrl_rd[BIT_PERMIT] = permit_q;
        ctrl_rd[BIT_AUTO] = auto_q;
        ctrl_rd[BIT_SEEN] = seen_q;
        ctrl_rd[PRI_LSB +: PRI_W] = prio_q;
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    AST_BUSY_WHEN_ON: assert property (@(posedge clk_sys) disable iff (rst) // [RL1]
        on_q |-> ctrl_rd[BIT_BUSY]) else $error("busy low while channel on");
    AST_BUSY_CLEARS: assert property (@(posedge clk_sys) disable iff (rst) // [RL1]
        !on_q && !active |-> !ctrl_rd[BIT_BUSY]) else $error("busy high while idle and off");
    AST_AUTO_OFF: assert property (@(posedge clk_sys) disable iff (rst) // [RL7]
        block_done && !auto_q && !chain_hit && !wr_en |=> !on_q) else $error("channel stayed on after block");
    AST_AUTO_KEEP: assert property (@(posedge clk_sys) disable iff (rst) // [RL7]
        on_q && block_done && auto_q && !wr_en |=> on_q) else $error("auto enable lost on block end");
    AST_CHAIN_ON: assert property (@(posedge clk_sys) disable iff (rst) // [RL6]
        chain_src && permit_q |=> on_q) else $error("chained start ignored");
    AST_NO_CHAIN: assert property (@(posedge clk_sys) disable iff (rst) // [RL6]
        !permit_q && !on_q && !wr_en |=> !on_q) else $error("channel enabled without permit");
    AST_EVT_SEEN: assert property (@(posedge clk_sys) disable iff (rst) // [RL8]
        start_evt && accept && !abort_evt |=> ctrl_rd[BIT_SEEN] && pending_q) else $error("start event not recorded");
    AST_EVT_IGNORED: assert property (@(posedge clk_sys) disable iff (rst) // [RL5]
        start_evt && !on_q && !allow_q && !seen_q && !pending_q |=> !seen_q && !pending_q)
        else $error("start event taken while off");
    AST_RSVD_ZERO: assert property (@(posedge clk_sys) disable iff (rst) // [RL11]
        ctrl_rd[31:16] == 16'h0000 && ctrl_rd[14:9] == 6'h00 && !ctrl_rd[3]) else $error("reserved bit set");

endmodule

`default_nettype wire

/* File: dcc_bus_model.sv */
/*
 * System bus model for the dma channel control block: it answers each
 * transaction request with a one-cycle acknowledge after a set wait.
 * Assumes xfer_req stands until acknowledged and one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module dcc_bus_model
    import dcc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic xfer_req,
    input wire logic [CNT_W-1:0] wait_cycles,
    output logic xfer_ack
);
    logic [CNT_W-1:0] wait_q;

    // ack only once the request has stood for wait_cycles, so slow buses are exercised too
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wait_q <= '0;
            xfer_ack <= 1'b0;
        end else if (xfer_ack) begin
            wait_q <= '0;
            xfer_ack <= 1'b0;
        end else if (xfer_req && wait_q >= wait_cycles) begin
            xfer_ack <= 1'b1;
        end else if (xfer_req) begin
            wait_q <= wait_q + 8'h01;
        end else begin
            wait_q <= '0;
        end
    end
endmodule

`default_nettype wire

/* File: tb.sv */
/*
 * Self-checking testbench of the dma channel control block.
 * Assumes dcc_pkg, dcc_top and the bus model dcc_bus_model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module tb
    import dcc_pkg::*;
();
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [ADR_W-1:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [NUM_CH-1:0] start_evt = 4'h0;
    logic [NUM_CH-1:0] abort_evt = 4'h0;
    logic xfer_req;
    logic [CH_W-1:0] xfer_chan;
    logic xfer_ack;
    logic irq;
    logic [CNT_W-1:0] bus_wait = 8'h03;
    logic [CH_W-1:0] log_q[$];
    int err_total = 0;
    int checks = 0;

    always #2 clk_sys = ~clk_sys;

    dcc_top dcc_top_inst (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .start_evt(start_evt), .abort_evt(abort_evt),
        .xfer_req(xfer_req), .xfer_chan(xfer_chan), .xfer_ack(xfer_ack), .irq(irq));

    dcc_bus_model dcc_bus_model_inst (.clk_sys(clk_sys), .rst(rst), .xfer_req(xfer_req),
        .wait_cycles(bus_wait), .xfer_ack(xfer_ack));

    // record the channel of every finished transaction
    always @(posedge clk_sys) begin
        if (xfer_req === 1'b1 && xfer_ack === 1'b1) begin
            log_q.push_back(xfer_chan);
        end
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic final_report();
        if (err_total == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk_sys);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_dat <= d;
        wb_sel <= 4'hf;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 100);
        r = wb_dat_o;
        if (n >= 100) chk("wb ack", 32'h0, 32'h1);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb(1'b1, a, d, r);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
        logic [31:0] r;
        wb(1'b0, a, 32'h0, r);
        chk(nm, r, e);
    endtask

    task automatic ck_irq(input logic e);
        @(posedge clk_sys);
        chk("irq", {31'h0, irq}, {31'h0, e});
    endtask

    task automatic pulse(input logic [3:0] s, input logic [3:0] a);
        @(posedge clk_sys);
        start_evt <= s;
        abort_evt <= a;
        @(posedge clk_sys);
        start_evt <= 4'h0;
        abort_evt <= 4'h0;
    endtask

    task automatic wait_log(input int n);
        int k;
        k = 0;
        while (log_q.size() < n && k < 500) begin
            @(posedge clk_sys);
            k++;
        end
        chk("txn count", 32'(log_q.size()), 32'(n));
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        for (int i = 0; i < NUM_CH; i++) begin
            rd(8'(4 * i), 32'h0, "ctrl reset");
        end
        rd(INT_STAT_OFS, 32'h0, "status reset");
        rd(INT_MASK_OFS, 32'h0, "mask reset");
        rd(8'h80, 32'h0, "unmapped");
        wr(8'h00, 32'hffffffff);
        rd(8'h00, 32'h000081f3, "ctrl all ones");
        wr(8'h00, 32'h0);
        rd(8'h00, 32'h0, "ctrl off");
    endtask

    task automatic t_block();
        for (int a = 0; a < 2; a++) begin
            wr(INT_MASK_OFS, 32'h01);
            wr(8'h00, a ? 32'h90 : 32'h80);
            log_q = {};
            pulse(4'h1, 4'h0);
            rd(8'h00, a ? 32'h8094 : 32'h8084, "event seen");
            wait_log(4);
            rd(8'h00, a ? 32'h8090 : 32'h0, "after block");
            ck_irq(1'b1);
            rd(INT_STAT_OFS, 32'h01, "block status");
            wr(INT_STAT_OFS, 32'h01);
            ck_irq(1'b0);
            wr(8'h00, 32'h0);
        end
    endtask

    task automatic t_events();
        wr(8'h0c, 32'h0);
        pulse(4'h8, 4'h0);
        rd(8'h0c, 32'h0, "start ignored");
        wr(8'h0c, 32'h40);
        pulse(4'h8, 4'h0);
        rd(8'h0c, 32'h44, "start kept");
        pulse(4'h0, 4'h8);
        rd(8'h0c, 32'h40, "abort kept");
        rd(INT_STAT_OFS, 32'h80, "abort status");
        ck_irq(1'b0);
        wr(INT_MASK_OFS, 32'h80);
        ck_irq(1'b1);
        wr(INT_STAT_OFS, 32'h80);
        ck_irq(1'b0);
        wr(8'h0c, 32'h0);
    endtask

    task automatic t_chain();
        logic [31:0] cw[5] = '{32'h020, 32'h120, 32'h000, 32'h100, 32'h020};
        logic [31:0] ce[5] = '{32'h80a0, 32'h81a0, 32'h000, 32'h100, 32'h020};
        int src[5] = '{0, 2, 0, 2, 2};
        for (int i = 0; i < 5; i++) begin
            wr(8'h04, cw[i]);
            wr(8'(4 * src[i]), 32'h80);
            log_q = {};
            pulse(4'(1 << src[i]), 4'h0);
            wait_log(4);
            rd(8'h04, ce[i], "chained word");
            wr(8'h04, 32'h0);
            wr(INT_STAT_OFS, 32'hff);
        end
    endtask

    task automatic t_prio();
        logic [31:0] e;
        for (int p = 0; p < 4; p++) begin
            e = (p > 1) ? 32'h3 : 32'h0;
            wr(8'h00, 32'h81);
            wr(8'h0c, 32'(32'h80 | p));
            log_q = {};
            pulse(4'h9, 4'h0);
            wait_log(8);
            chk("first grant", {30'h0, log_q[0]}, e);
            chk("second grant", {30'h0, log_q[4]}, 32'h3 - e);
        end
        wr(INT_STAT_OFS, 32'hff);
    endtask

    task automatic t_suspend();
        logic [31:0] r;
        int k;
        bus_wait <= 8'h28;
        wr(8'h00, 32'h80);
        log_q = {};
        pulse(4'h1, 4'h0);
        k = 0;
        while (xfer_req !== 1'b1 && k < 50) begin
            @(posedge clk_sys);
            k++;
        end
        wr(8'h00, 32'h0);
        rd(8'h00, 32'h8004, "busy while finishing");
        k = 0;
        do begin
            wb(1'b0, 8'h00, 32'h0, r);
            k++;
        end while (r[BIT_BUSY] !== 1'b0 && k < 40);
        chk("suspended word", r, 32'h0004);
        chk("txn count", 32'(log_q.size()), 32'h1);
        bus_wait <= 8'h03;
        wr(8'h00, 32'h40);
        pulse(4'h0, 4'h1);
        rd(8'h00, 32'h40, "abort clears");
        wr(8'h00, 32'h0);
        wr(INT_STAT_OFS, 32'hff);
    endtask

    initial begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        t_reset();
        t_block();
        t_events();
        t_chain();
        t_prio();
        t_suspend();
        final_report();
    end

    // whole run takes about a thousand cycles; this cuts a hang short
    initial begin
        repeat (30000) @(posedge clk_sys);
        err_total++;
        final_report();
    end
endmodule

`default_nettype wire
